// ### hdl/output_voltage_limit_slew_regs.v
// slew rate, loop scale and lower output limit command registers
//
// Overview of operation
// - slew exponent fixed at minus four
// - valid slew code stored; its mantissa used as the step
// - slew span 0.125 to 15.875 mV/us
// - out-of-range writes flag invalid data
// - loop scale quantised to four divider steps
// - loop scale hardware update held while converting
// - reference scaling uses stored loop scale
// - lower limit unsigned, effective at once
// - low target clamps to limit, warns, while converting
// - violation sets status bits, notifies host
// - limit write over target responds same
// - slew applied only in normal conversion
`timescale 1ns/1ps
`default_nettype none
`include "vout_limit_defs.vh"
module output_voltage_limit_slew_regs #(
    parameter [15:0] LIMIT_MAX = 16'hFFFF
) (
    input wire sys_clk,
    input wire nrst,
    input wire wr_stb,
    input wire rd_stb,
    input wire [7:0] cmd_code,
    input wire [15:0] wr_data,
    output reg [15:0] rd_data,
    output reg rd_valid,
    input wire conversion_en,
    input wire ramping_on_off,
    input wire store_restore_stb,
    input wire analog_supply_undervoltage_lockout,
    input wire [15:0] vout_target,
    input wire target_change_stb,
    output reg [15:0] vout_out_q,
    output reg [10:0] slew_mantissa_hw_q,
    output wire slew_active,
    output reg [1:0] divider_sel_q,
    output reg [15:0] ref_scale_word_q,
    output reg invalid_data_q,
    output reg none_of_above_q,
    output reg status_vout_q,
    output reg min_max_warn_q,
    output reg notify_pulse_q,
    input wire status_clear
);
    reg [15:0] slew_q;
    reg [15:0] loop_scale_q;
    reg [15:0] lower_limit_q;
    reg [1:0] pending_div_q;
    reg pending_q;
    reg [15:0] goal_q;

    // sign-extended mantissa and exponent of a linear word
    function signed [11:0] man_of;
        input [15:0] w;
        man_of = {w[`MAN_MSB], w[`MAN_MSB:0]};
    endfunction
    function signed [4:0] exp_of;
        input [15:0] w;
        exp_of = w[`EXP_MSB:`EXP_LSB];
    endfunction

    // decoded value compared in units of 2^-16: mantissa shifted by exp+16
    function [31:0] lin_fixed;
        input [15:0] w;
        reg signed [11:0] m;
        reg signed [5:0] s;
        begin
            m = man_of(w);
            // exponent plus sixteen; never negative as exp >= -16
            s = {w[`EXP_MSB], exp_of(w)} + 6'sd16;
            if (m[11] || s[5])
                lin_fixed = 32'h00000000;
            else if (s[4:0] > 5'h15)
                // ten mantissa bits past bit 31 would wrap to a small value
                lin_fixed = 32'hFFFFFFFF;
            else
                lin_fixed = {20'h00000, m} << s[4:0];
        end
    endfunction

    wire [31:0] scale_fx = lin_fixed(wr_data);
    wire [1:0] div_of_write =
        (scale_fx <= 32'h00002000) ? `DIV_0125 :
        (scale_fx <= 32'h00004000) ? `DIV_025 :
        (scale_fx <= 32'h00008000) ? `DIV_05 : `DIV_1;

    // fixed exponent; 0.125..15.875 at 0.0625 per count
    wire slew_ok = (wr_data[`EXP_MSB:`EXP_LSB] == `SLEW_EXP_FIXED) &&
        (wr_data[`MAN_MSB:0] >= `SLEW_MAN_MIN) &&
        (wr_data[`MAN_MSB:0] <= `SLEW_MAN_MAX);
    wire scale_ok = !wr_data[`MAN_MSB] && (wr_data[`MAN_MSB:0] != 11'h000)
        && (scale_fx <= 32'h00010000);
    wire limit_ok = wr_data <= LIMIT_MAX;

    wire wr_slew = wr_stb && cmd_code == `CMD_OUTPUT_SLEW_RATE;
    wire wr_scale = wr_stb && cmd_code == `CMD_FEEDBACK_LOOP_SCALE;
    wire wr_limit = wr_stb && cmd_code == `CMD_OUTPUT_LOWER_LIMIT;
    wire limit_take = wr_limit && limit_ok;
    wire [15:0] limit_now = limit_take ? wr_data : lower_limit_q;
    wire bad_write = (wr_slew && !slew_ok) || (wr_scale && !scale_ok) ||
        (wr_limit && !limit_ok);
    // a fresh target replaces the goal before the limit is checked
    wire [15:0] goal_raw = target_change_stb ? vout_target : goal_q;
    wire target_low = target_change_stb && vout_target < limit_now;
    // limit write over present target behaves like a violating change
    wire limit_over = limit_take && goal_raw < wr_data;
    wire viol = conversion_en && (target_low || limit_over);
    wire [15:0] goal_d = viol ? limit_now : goal_raw;
    wire hw_release = !conversion_en || store_restore_stb ||
        analog_supply_undervoltage_lockout;

    // slewing only during normal conversion, not on/off ramps
    assign slew_active = conversion_en && !ramping_on_off &&
        (vout_out_q != goal_q);

    // one slew step of the output toward its goal, never past it
    function [15:0] step_toward;
        input [15:0] cur;
        input [15:0] goal;
        input [10:0] step;
        reg [15:0] gap;
        reg [15:0] inc;
        begin
            inc = {5'h00, step};
            gap = (goal > cur) ? goal - cur : cur - goal;
            if (gap <= inc)
                step_toward = goal;
            else if (goal > cur)
                step_toward = cur + inc;
            else
                step_toward = cur - inc;
        end
    endfunction

    wire slew_take = wr_slew && slew_ok;
    wire scale_take = wr_scale && scale_ok;
    // on/off ramps and idle jump straight to the goal
    wire [15:0] vout_d = (!conversion_en || ramping_on_off) ? goal_q :
        step_toward(vout_out_q, goal_q, slew_mantissa_hw_q);

    // command words as written, read back unchanged
    always @(posedge sys_clk) begin
        if (!nrst) begin
            slew_q <= `SLEW_RESET;
            loop_scale_q <= `LOOP_SCALE_RESET;
            lower_limit_q <= `LOWER_LIMIT_RESET;
            slew_mantissa_hw_q <= `SLEW_MAN_RESET;
        end else begin
            if (slew_take) begin
                slew_q <= wr_data;
                slew_mantissa_hw_q <= wr_data[`MAN_MSB:0];
            end
            if (scale_take)
                loop_scale_q <= wr_data;
            if (limit_take)
                lower_limit_q <= wr_data;
        end
    end

    // divider follows at once when idle, else waits for a release event
    always @(posedge sys_clk) begin
        if (!nrst) begin
            pending_div_q <= `DIV_0125;
            pending_q <= 1'b0;
            divider_sel_q <= `DIV_0125;
            ref_scale_word_q <= `LOOP_SCALE_RESET;
        end else begin
            if (scale_take) begin
                // stored value steers scaling even when unsupported
                ref_scale_word_q <= wr_data;
            end
            if (scale_take && !conversion_en) begin
                divider_sel_q <= div_of_write;
                pending_q <= 1'b0;
            end else if (scale_take) begin
                // a newer write replaces any value still waiting
                pending_div_q <= div_of_write;
                pending_q <= 1'b1;
            end else if (pending_q && hw_release) begin
                divider_sel_q <= pending_div_q;
                pending_q <= 1'b0;
            end
        end
    end

    // output goal and slewed output code
    always @(posedge sys_clk) begin
        if (!nrst) begin
            goal_q <= 16'h0000;
            vout_out_q <= 16'h0000;
        end else begin
            goal_q <= goal_d;
            vout_out_q <= vout_d;
        end
    end

    // sticky status bits and a one-cycle notify pulse: an event in the clearing cycle still sets the sticky bits
    always @(posedge sys_clk) begin
        if (!nrst) begin
            invalid_data_q <= 1'b0;
            none_of_above_q <= 1'b0;
            status_vout_q <= 1'b0;
            min_max_warn_q <= 1'b0;
            notify_pulse_q <= 1'b0;
        end else begin
            invalid_data_q <= bad_write ||
                (invalid_data_q && !status_clear);
            none_of_above_q <= viol ||
                (none_of_above_q && !status_clear);
            status_vout_q <= viol ||
                (status_vout_q && !status_clear);
            min_max_warn_q <= viol ||
                (min_max_warn_q && !status_clear);
            notify_pulse_q <= viol || bad_write;
        end
    end

    // read answer one cycle after the strobe; data stands until next read
    always @(posedge sys_clk) begin
        if (!nrst) begin
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_stb;
            if (rd_stb) begin
                case (cmd_code)
                    `CMD_OUTPUT_SLEW_RATE: rd_data <= slew_q;
                    `CMD_FEEDBACK_LOOP_SCALE: rd_data <= loop_scale_q;
                    `CMD_OUTPUT_LOWER_LIMIT: rd_data <= lower_limit_q;
                    default: rd_data <= 16'h0000;
                endcase
            end
        end
    end
endmodule // output_voltage_limit_slew_regs
`default_nettype wire

// ### hdl/vout_limit_defs.vh
// constants for the output slew, loop scale and lower limit registers
`ifndef VOUT_LIMIT_DEFS_VH
`define VOUT_LIMIT_DEFS_VH
`define CMD_OUTPUT_SLEW_RATE 8'h27
`define CMD_FEEDBACK_LOOP_SCALE 8'h29
`define CMD_OUTPUT_LOWER_LIMIT 8'h2B
`define EXP_MSB 15
`define EXP_LSB 11
`define MAN_MSB 10
`define SLEW_EXP_FIXED 5'h1C
`define SLEW_RESET 16'hE010
`define SLEW_MAN_RESET 11'h010
`define LOOP_SCALE_RESET 16'hC808
`define LOWER_LIMIT_RESET 16'h0000
`define SLEW_MAN_MIN 11'h002
`define SLEW_MAN_MAX 11'h0FE
`define DIV_0125 2'h0
`define DIV_025 2'h1
`define DIV_05 2'h2
`define DIV_1 2'h3
`define SLEW_STEP 11'h001
`endif

// ### tb/output_voltage_limit_slew_regs_tb.sv
// self-checking bench for the slew, loop scale and lower limit registers
`timescale 1ns/1ps
`default_nettype none
module output_voltage_limit_slew_regs_tb;
    logic sys_clk = 1'b0, nrst = 1'b0, conv = 1'b0, ramp = 1'b0;
    logic sr = 1'b0, undervoltage_lockout = 1'b0, tchg = 1'b0, sclr = 1'b0;
    logic [15:0] tgt = 16'h0000, v;
    wire wr_stb, rd_stb, rd_valid, inv, warn, sact;
    wire [10:0] smh;
    wire [7:0] cmd_code;
    wire [15:0] wr_data, rd_data, vout, rsw;
    wire [1:0] div;
    int n_errors = 0, checks = 0, cyc = 0, i;
    logic [15:0] sc [5] = '{16'hC810, 16'hC811, 16'hC820, 16'hC840, 16'hC880};
    logic [1:0] dv [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    always #5 sys_clk = ~sys_clk;
    output_voltage_limit_slew_regs u_dut (.sys_clk, .nrst, .wr_stb, .rd_stb,
        .cmd_code, .wr_data, .rd_data, .rd_valid, .conversion_en(conv),
        .ramping_on_off(ramp), .store_restore_stb(sr),
        .analog_supply_undervoltage_lockout(undervoltage_lockout), .vout_target(tgt),
        .target_change_stb(tchg), .vout_out_q(vout),
        .slew_mantissa_hw_q(smh), .slew_active(sact), .divider_sel_q(div),
        .ref_scale_word_q(rsw), .invalid_data_q(inv), .none_of_above_q(),
        .status_vout_q(), .min_max_warn_q(warn), .notify_pulse_q(),
        .status_clear(sclr));
    pmbus_host_model u_host (.sys_clk, .rd_valid, .rd_data, .wr_stb,
        .rd_stb, .cmd_code, .wr_data);
    task automatic chk(input string s, input logic [15:0] e, g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge sys_clk) s = 1'b1;
        @(negedge sys_clk) s = 1'b0;
    endtask
    // output moves by the slew step, so wait with a bound
    task automatic settle(input logic [15:0] e);
        repeat (300) if (vout !== e) @(negedge sys_clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            report_and_stop;
        end
    end
    initial begin
        repeat (20) @(negedge sys_clk);
        nrst = 1'b1;
        u_host.rd(8'h27, v);
        chk("slew reset", 16'hE010, v);
        u_host.wr(8'h27, 16'hE0FE);
        u_host.rd(8'h27, v);
        chk("slew max", 16'hE0FE, v);
        chk("slew hw", 16'h00FE, {5'h0, smh});
        u_host.wr(8'h27, 16'hE0FF);
        u_host.rd(8'h27, v);
        chk("slew over", 16'hE0FE, v);
        chk("invalid", 16'h0001, {15'h0, inv});
        pulse(sclr);
        chk("inv clear", 16'h0000, {15'h0, inv});
        u_host.wr(8'h27, 16'hD810);
        chk("slew exp", 16'h0001, {15'h0, inv});
        pulse(sclr);
        u_host.wr(8'h27, 16'hE001);
        chk("slew min", 16'h0001, {15'h0, inv});
        pulse(sclr);
        for (i = 0; i < 5; i++) begin
            u_host.wr(8'h29, sc[i]);
            chk("divider", {14'h0, dv[i]}, {14'h0, div});
            chk("scale word", sc[i], rsw);
        end
        u_host.wr(8'h29, 16'hC800);
        chk("scale zero", 16'hC880, rsw);
        conv = 1'b1;
        u_host.wr(8'h29, 16'hC810);
        chk("div held", 16'h0003, {14'h0, div});
        pulse(sr);
        chk("div free", 16'h0000, {14'h0, div});
        u_host.wr(8'h2B, 16'h0100);
        u_host.rd(8'h2B, v);
        chk("limit", 16'h0100, v);
        chk("limit over", 16'h0001, {15'h0, warn});
        settle(16'h0100);
        pulse(sclr);
        chk("warn clear", 16'h0000, {15'h0, warn});
        tgt = 16'h0080;
        pulse(tchg);
        settle(16'h0100);
        chk("clamp", 16'h0100, vout);
        chk("warn", 16'h0001, {15'h0, warn});
        tgt = 16'h0200;
        pulse(tchg);
        @(negedge sys_clk);
        chk("slew step", 16'h01FE, vout);
        chk("slewing", 16'h0001, {15'h0, sact});
        pulse(sclr);
        settle(16'h0200);
        u_host.wr(8'h2B, 16'h0300);
        settle(16'h0300);
        chk("limit clamp", 16'h0300, vout);
        chk("limit warn", 16'h0001, {15'h0, warn});
        chk("settled", 16'h0000, {15'h0, sact});
        ramp = 1'b1;
        tgt = 16'h1000;
        pulse(tchg);
        @(negedge sys_clk);
        chk("ramp jump", 16'h1000, vout);
        ramp = 1'b0;
        report_and_stop;
    end
endmodule // output_voltage_limit_slew_regs_tb
`default_nettype wire

// ### tb/pmbus_host_model.sv
// word read and write host on the command port
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
    input wire logic sys_clk, rd_valid,
    input wire logic [15:0] rd_data,
    output logic wr_stb, rd_stb,
    output logic [7:0] cmd_code,
    output logic [15:0] wr_data
);
    initial {wr_stb, rd_stb, cmd_code, wr_data} = 26'h0;
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge sys_clk);
        cmd_code = c;
        wr_data = d;
        wr_stb = 1'b1;
        @(negedge sys_clk);
        wr_stb = 1'b0;
        wr_data = ~d;
    endtask
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        @(negedge sys_clk);
        cmd_code = c;
        rd_stb = 1'b1;
        @(negedge sys_clk);
        rd_stb = 1'b0;
        d = rd_valid ? rd_data : 16'hXXXX;
    endtask
endmodule // pmbus_host_model
`default_nettype wire

// ### tb/vout_regs_sva.sv
// assertion checker for the slew, loop scale and lower limit registers
`timescale 1ns/1ps
`default_nettype none
module vout_regs_sva (
    input wire logic sys_clk, nrst, wr_stb, rd_stb, rd_valid,
    input wire logic conversion_en, store_restore_stb, analog_supply_undervoltage_lockout,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] wr_data,
    input wire logic [1:0] divider_sel_q,
    input wire logic invalid_data_q, none_of_above_q, status_vout_q,
    input wire logic min_max_warn_q, notify_pulse_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire scale_wr = wr_stb && cmd_code == 8'h29;
    chk_read_answer: assert property (rd_stb |=> rd_valid)
        else $error("read not answered");
    chk_no_stray: assert property (!rd_stb |=> !rd_valid)
        else $error("stray read answer");
    chk_slew_exp: assert property (wr_stb && cmd_code == 8'h27 &&
        wr_data[15:11] != 5'h1C |=> invalid_data_q && notify_pulse_q)
        else $error("bad slew exponent kept");
    chk_scale_zero: assert property (scale_wr &&
        wr_data[10:0] == 11'h000 |=> invalid_data_q)
        else $error("zero scale not refused");
    chk_scale_now: assert property (!conversion_en && scale_wr &&
        wr_data == 16'hC840 |=> divider_sel_q == 2'h2)
        else $error("half scale divider wrong");
    chk_scale_held: assert property (conversion_en &&
        $past(conversion_en) && $past(nrst) && !$past(store_restore_stb)
        && !$past(analog_supply_undervoltage_lockout) |-> $stable(divider_sel_q))
        else $error("divider moved while converting");
    chk_warn_bits: assert property (min_max_warn_q |->
        status_vout_q && none_of_above_q)
        else $error("warning without status bits");
    chk_warn_notify: assert property ($rose(min_max_warn_q) |->
        notify_pulse_q)
        else $error("warning without notify");
    cover property (scale_wr && conversion_en);
    cover property ($rose(min_max_warn_q));
    cover property ($rose(invalid_data_q));
endmodule // vout_regs_sva
bind output_voltage_limit_slew_regs vout_regs_sva u_sva (.sys_clk, .nrst,
    .wr_stb, .rd_stb, .rd_valid, .conversion_en, .store_restore_stb,
    .analog_supply_undervoltage_lockout, .cmd_code, .wr_data, .divider_sel_q,
    .invalid_data_q, .none_of_above_q, .status_vout_q, .min_max_warn_q,
    .notify_pulse_q);
`default_nettype wire
